// file: inc/stic_consts.svh
// constants of the serial time interval counter: widths, command codes, status bit positions
`ifndef STIC_CONSTS_SVH
`define STIC_CONSTS_SVH

// ----------------------------------------------------------------------
// widths and memory geometry
// ----------------------------------------------------------------------
`define CNT_W          24
`define ADDR_W         10
`define MEM_DEPTH      1024
`define DATA_W         24
`define CNT_ZERO       24'h000000
`define CNT_ALL_ONES   24'hffffff
`define CNT_ONE        24'h000001
`define ADDR_ZERO      10'h000
`define ADDR_ONE       10'h001
`define ADDR_LAST      10'h3ff

// ----------------------------------------------------------------------
// command codes: function and subaddress
// ----------------------------------------------------------------------
`define FN_RD_ADDR     5'h00
`define FN_RD_STATUS   5'h01
`define FN_RD_COUNT    5'h02
`define FN_RD_MODNUM   5'h06
`define FN_WR_ADDR     5'h10
`define FN_DISARM      5'h18
`define FN_ARM         5'h1a
`define SUB_MAIN       4'h0

// ----------------------------------------------------------------------
// status word bit positions (read line n sits in bit n-1)
// ----------------------------------------------------------------------
`define ST_STOPS_LO    0
`define ST_SRC_BIT     16
`define ST_DIV_LO      17
`define ST_ARMED_BIT   19
`define ST_COUNT_BIT   20
`define ST_FULL_BIT    21
`define ST_OVF_BIT     22
`define ST_STOVF_BIT   23

// ----------------------------------------------------------------------
// clock divider and identity
// ----------------------------------------------------------------------
`define DEC_ZERO       4'h0
`define DEC_ONE        4'h1
`define DEC_LAST       4'h9
`define MODNUM_DEFAULT 12'h0a5

// ----------------------------------------------------------------------
// positions of the front pins inside the synchroniser vector
// ----------------------------------------------------------------------
`define PIN_W          8
`define PIN_DWCLK      0
`define PIN_EXTCLK     1
`define PIN_START      2
`define PIN_STOP       3
`define PIN_DISARM     4
`define PIN_SRCEXT     5
`define PIN_DIV_LO     6

`endif

// file: inc/stic_pkg.sv
// types of the serial time interval counter
package stic_pkg;

   // run state, one-hot
   typedef enum logic [2:0] {
      RUN_IDLE  = 3'b001,
      RUN_ARMED = 3'b010,
      RUN_COUNT = 3'b100
   } runState_t;

   // counting clock ratio picked by the board switch
   typedef enum logic [1:0] {
      DIV_BY_1    = 2'h0,
      DIV_BY_10   = 2'h1,
      DIV_BY_100  = 2'h2,
      DIV_BY_1000 = 2'h3
   } divSel_t;

endpackage : stic_pkg

// file: logic/result_memory.sv
// result memory: 1024 words of 24 bits with a registered read port
`timescale 1ns/100ps
`include "stic_consts.svh"

module result_memory (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 wrEn,
   input  wire logic [`ADDR_W-1:0]   wrAddr,
   input  wire logic [`DATA_W-1:0]   wrWord,
   input  wire logic                 rdEn,
   input  wire logic [`ADDR_W-1:0]   rdAddr,
   input  wire logic [`DATA_W-1:0]   altWord,
   output logic      [`DATA_W-1:0]   rdWord
);

   logic [`DATA_W-1:0] memArray [`MEM_DEPTH];
   logic [`DATA_W-1:0] rdWord_d;

   // the read register doubles as the bus read register, so the top output stays a flop
   always_comb begin
      rdWord_d = rdEn ? memArray[rdAddr] : altWord;
   end

   // array has no reset: contents are only meaningful after a run wrote them
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrWord;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdWord <= '0;
      end else begin
         rdWord <= rdWord_d;
      end
   end

endmodule : result_memory

// file: logic/serial_time_interval_counter.sv
// serial time interval counter: start/stop capture, clock divider, command decode
//
// Functional notes
// R1: result memory holds 1024 words of 24-bit interval counts per run.
// R2: arm clears counter and address register, then enters armed state.
// R3: only first start after arm begins counting; later starts ignored.
// R4: each valid stop stores running count at current address; counter keeps running.
// R5: counter reaching all ones stops storing, zeroes counter and address, disarms.
// R6: after 1024th word, stop storing, zero counter and address, no overwrite.
// R7: arm during a run ends it; next start begins a new run.
// R8: disarm command or external disarm pulse ends run, zeroes, leaves disarmed.
// R9: counts internal 1 MHz bus clock or external clock, chosen by switch.
// R10: divided clocks of 1/10, 1/100, 1/1000; switch picks counting clock.
// R11: after power-up disarmed; needs arm then start before counting.
// R12: interval counter never readable; reaches software only through memory.
// R13: answer X high for every supported command, including Z+C.
// R14: decode reads F0,F1,F2,F6 and writes F16,F24,F26 at subaddress 0.
// R15: far side spaces stops at least 1 us from start and previous stop.
// R16: interval read returns memory word at address, then address increments.
// R17: while armed refuse address read, address write, count read with Q low.
// R18: status holds stop count, source, divider, armed, counting, full, overflow flags.
// R19: Z+C disarms, stops run, zeroes counter, address, stop count and flags.
// R20: start, stop, disarm pins are synchronised; each rising edge acts once.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "stic_consts.svh"

module serial_time_interval_counter #(
   parameter logic [11:0] MODULE_NUMBER = `MODNUM_DEFAULT  // arbitrary identity value
) (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire logic [4:0]            cmdFunc,
   input  wire logic [3:0]            cmdSub,
   input  wire logic [`DATA_W-1:0]    wrData,
   input  wire logic                  wrStrobe,
   input  wire logic                  rdStrobe,
   input  wire logic                  initClear,
   input  wire logic                  dwClkIn,
   input  wire logic                  extClkIn,
   input  wire logic                  startIn,
   input  wire logic                  stopIn,
   input  wire logic                  extDisarmIn,
   input  wire logic                  clkSrcExtSw,
   input  wire stic_pkg::divSel_t     divSelSw,
   output logic      [`DATA_W-1:0]    rdData,
   output logic                       qResp,
   output logic                       xResp
);
   import stic_pkg::*;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [`PIN_W-1:0]  syncA_q, syncA_d;
   logic [`PIN_W-1:0]  syncB_q, syncB_d;
   logic [`PIN_W-1:0]  edgeRef_q, edgeRef_d;
   logic [`PIN_W-1:0]  riseEdge;
   logic               srcTick;
   logic               countTick;
   divSel_t            divSel;
   logic [3:0]         dec1_q, dec1_d;
   logic [3:0]         dec2_q, dec2_d;
   logic [3:0]         dec3_q, dec3_d;
   logic               tick10;
   logic               tick100;
   logic               tick1000;
   runState_t          state_q, state_d;
   logic [`CNT_W-1:0]  count_q, count_d;
   logic [`ADDR_W-1:0] addr_q, addr_d;
   logic [`ADDR_W-1:0] stops_q, stops_d;
   logic               full_q, full_d;
   logic               ovf_q, ovf_d;
   logic               stopOvf_q, stopOvf_d;
   logic               qResp_d;
   logic               xResp_d;
   logic               memWrEn;
   logic               memRdEn;
   logic [`DATA_W-1:0] altWord;
   logic [`DATA_W-1:0] statusWord;
   logic               armedNow;
   logic               startPulse;
   logic               stopPulse;
   logic               disarmPulse;
   logic               cmdArm;
   logic               cmdDisarm;
   logic               cmdWrAddr;
   logic               cmdRdAddr;
   logic               cmdRdStatus;
   logic               cmdRdCount;
   logic               cmdRdModnum;

   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------

   // match one function code at the only subaddress the module answers
   function automatic logic isCmd(input logic [4:0] fn,
                                  input logic [3:0] sub,
                                  input logic [4:0] code);
      isCmd = (fn == code) && (sub == `SUB_MAIN);
   endfunction : isCmd

   // decade counter step, wraps nine back to zero
   function automatic logic [3:0] decadeNext(input logic [3:0] v);
      decadeNext = (v == `DEC_LAST) ? `DEC_ZERO : v + `DEC_ONE;
   endfunction : decadeNext

   // ------------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------------

   // two flops per pin; edges only look at the second stage and its delayed copy
   always_comb begin
      syncA_d   = {divSelSw, clkSrcExtSw, extDisarmIn, stopIn, startIn, extClkIn, dwClkIn};
      syncB_d   = syncA_q;
      edgeRef_d = syncB_q;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_q   <= '0;
         syncB_q   <= '0;
         edgeRef_q <= '0;
      end else begin
         syncA_q   <= syncA_d;
         syncB_q   <= syncB_d;
         edgeRef_q <= edgeRef_d;
      end
   end

   // one pulse per rising edge, so a long pulse acts only once
   assign riseEdge    = syncB_q & ~edgeRef_q;                          // R20
   assign startPulse  = riseEdge[`PIN_START];                          // R20
   assign stopPulse   = riseEdge[`PIN_STOP];                           // R20
   assign disarmPulse = riseEdge[`PIN_DISARM];                         // R20
   assign divSel      = divSel_t'(syncB_q[`PIN_DIV_LO +: 2]);

   // source pick: bus clock or front clock, both sampled at mclk
   assign srcTick = syncB_q[`PIN_SRCEXT] ? riseEdge[`PIN_EXTCLK]       // R9
                                         : riseEdge[`PIN_DWCLK];

   // ------------------------------------------------------------------
   // decade clock dividers
   // ------------------------------------------------------------------

   // cascaded decades run free, so the ratio holds whether or not a run is on
   assign tick10   = srcTick && (dec1_q == `DEC_LAST);                 // R10
   assign tick100  = tick10 && (dec2_q == `DEC_LAST);                  // R10
   assign tick1000 = tick100 && (dec3_q == `DEC_LAST);                 // R10

   always_comb begin
      dec1_d = srcTick ? decadeNext(dec1_q) : dec1_q;
      dec2_d = tick10  ? decadeNext(dec2_q) : dec2_q;
      dec3_d = tick100 ? decadeNext(dec3_q) : dec3_q;
      case (divSel)                                                    // R10
         DIV_BY_1:    countTick = srcTick;
         DIV_BY_10:   countTick = tick10;
         DIV_BY_100:  countTick = tick100;
         DIV_BY_1000: countTick = tick1000;
         default:     countTick = srcTick;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dec1_q <= `DEC_ZERO;
         dec2_q <= `DEC_ZERO;
         dec3_q <= `DEC_ZERO;
      end else begin
         dec1_q <= dec1_d;
         dec2_q <= dec2_d;
         dec3_q <= dec3_d;
      end
   end

   // ------------------------------------------------------------------
   // command decode and status word
   // ------------------------------------------------------------------

   // writes carry F16/F24/F26, reads carry F0/F1/F2/F6
   assign cmdArm      = wrStrobe && isCmd(cmdFunc, cmdSub, `FN_ARM);       // R14
   assign cmdDisarm   = wrStrobe && isCmd(cmdFunc, cmdSub, `FN_DISARM);    // R14
   assign cmdWrAddr   = wrStrobe && isCmd(cmdFunc, cmdSub, `FN_WR_ADDR);   // R14
   assign cmdRdAddr   = rdStrobe && isCmd(cmdFunc, cmdSub, `FN_RD_ADDR);   // R14
   assign cmdRdStatus = rdStrobe && isCmd(cmdFunc, cmdSub, `FN_RD_STATUS); // R14
   assign cmdRdCount  = rdStrobe && isCmd(cmdFunc, cmdSub, `FN_RD_COUNT);  // R14
   assign cmdRdModnum = rdStrobe && isCmd(cmdFunc, cmdSub, `FN_RD_MODNUM); // R14

   // armed covers both waiting for start and counting
   assign armedNow = (state_q == RUN_ARMED) || (state_q == RUN_COUNT);

   // the running count is deliberately absent here
   always_comb begin
      statusWord                          = '0;                        // R12
      statusWord[`ST_STOPS_LO +: `ADDR_W] = stops_q;                   // R18
      statusWord[`ST_SRC_BIT]             = syncB_q[`PIN_SRCEXT];      // R18
      statusWord[`ST_DIV_LO +: 2]         = divSel;                    // R18
      statusWord[`ST_ARMED_BIT]           = armedNow;                  // R18
      statusWord[`ST_COUNT_BIT]           = (state_q == RUN_COUNT);    // R18
      statusWord[`ST_FULL_BIT]            = full_q;                    // R18
      statusWord[`ST_OVF_BIT]             = ovf_q;                     // R18
      statusWord[`ST_STOVF_BIT]           = stopOvf_q;                 // R18
   end

   // ------------------------------------------------------------------
   // run control, address register and bus answers
   // ------------------------------------------------------------------

   // run events first, then commands and resets override; clear has top priority
   always_comb begin
      state_d   = state_q;
      count_d   = count_q;
      addr_d    = addr_q;
      stops_d   = stops_q;
      full_d    = full_q;
      ovf_d     = ovf_q;
      stopOvf_d = stopOvf_q;
      memWrEn   = 1'b0;
      memRdEn   = 1'b0;
      altWord   = '0;
      qResp_d   = 1'b0;
      xResp_d   = 1'b0;

      case (state_q)
         RUN_IDLE: begin
            // late stop after an overflow is only flagged, never stored
            if (stopPulse && ovf_q) begin
               stopOvf_d = 1'b1;                                       // R18
            end
         end
         RUN_ARMED: begin
            if (startPulse) begin
               state_d = RUN_COUNT;                                    // R3
               count_d = `CNT_ZERO;
            end
         end
         RUN_COUNT: begin
            if (count_q == `CNT_ALL_ONES) begin
               // no stop is valid once the counter is full of ones
               ovf_d   = 1'b1;                                         // R5
               state_d = RUN_IDLE;                                     // R5
               count_d = `CNT_ZERO;                                    // R5
               addr_d  = `ADDR_ZERO;                                   // R5
               if (stopPulse) begin
                  stopOvf_d = 1'b1;
               end
            end else begin
               if (countTick) begin
                  count_d = count_q + `CNT_ONE;
               end
               if (stopPulse) begin
                  memWrEn = 1'b1;                                      // R4
                  stops_d = stops_q + `ADDR_ONE;
                  addr_d  = addr_q + `ADDR_ONE;                        // R4
                  if (addr_q == `ADDR_LAST) begin
                     // memory full: end the run so nothing is overwritten
                     full_d  = 1'b1;                                   // R6
                     state_d = RUN_IDLE;                               // R6
                     count_d = `CNT_ZERO;                              // R6
                     addr_d  = `ADDR_ZERO;                             // R6
                  end
               end
            end
         end
         default: begin
            state_d = RUN_IDLE;
         end
      endcase

      // address register write, refused while armed
      if (cmdWrAddr) begin
         xResp_d = 1'b1;                                               // R13
         qResp_d = !armedNow;                                          // R17
         if (!armedNow) begin
            addr_d = wrData[`ADDR_W-1:0];
         end
      end

      // reads: the memory read register carries every answer word
      if (cmdRdAddr) begin
         xResp_d = 1'b1;                                               // R13
         qResp_d = !armedNow;                                          // R17
         if (!armedNow) begin
            altWord[`ADDR_W-1:0] = addr_q;
         end
      end
      if (cmdRdStatus) begin
         xResp_d = 1'b1;                                               // R13
         qResp_d = 1'b1;
         altWord = statusWord;
      end
      if (cmdRdModnum) begin
         xResp_d      = 1'b1;                                          // R13
         qResp_d      = 1'b1;
         altWord[11:0] = MODULE_NUMBER;
      end
      if (cmdRdCount) begin
         xResp_d = 1'b1;                                               // R13
         qResp_d = !armedNow;                                          // R17
         if (!armedNow) begin
            memRdEn = 1'b1;                                            // R16
            addr_d  = addr_q + `ADDR_ONE;                              // R16
         end
      end

      // arm restarts everything, including a run in progress
      if (cmdArm) begin
         xResp_d   = 1'b1;                                             // R13
         qResp_d   = 1'b1;
         state_d   = RUN_ARMED;                                        // R2 R7
         count_d   = `CNT_ZERO;                                        // R2
         addr_d    = `ADDR_ZERO;                                       // R2
         stops_d   = `ADDR_ZERO;
         full_d    = 1'b0;
         ovf_d     = 1'b0;
         stopOvf_d = 1'b0;
      end

      // disarm wins over arm when both land in one cycle
      if (cmdDisarm || disarmPulse) begin
         xResp_d = xResp_d | cmdDisarm;                                // R13
         qResp_d = qResp_d | cmdDisarm;
         state_d = RUN_IDLE;                                           // R8
         count_d = `CNT_ZERO;                                          // R8
         addr_d  = `ADDR_ZERO;                                         // R8
      end

      // crate clear: disarm and wipe the run record
      if (initClear) begin
         xResp_d   = 1'b1;                                             // R13
         qResp_d   = 1'b0;
         state_d   = RUN_IDLE;                                         // R19
         count_d   = `CNT_ZERO;                                        // R19
         addr_d    = `ADDR_ZERO;                                       // R19
         stops_d   = `ADDR_ZERO;                                       // R19
         full_d    = 1'b0;                                             // R19
         ovf_d     = 1'b0;                                             // R19
         stopOvf_d = 1'b0;                                             // R19
      end
   end

   // power-up leaves the module disarmed and idle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= RUN_IDLE;                                        // R11
         count_q   <= `CNT_ZERO;
         addr_q    <= `ADDR_ZERO;
         stops_q   <= `ADDR_ZERO;
         full_q    <= 1'b0;
         ovf_q     <= 1'b0;
         stopOvf_q <= 1'b0;
         qResp     <= 1'b0;
         xResp     <= 1'b0;
      end else begin
         state_q   <= state_d;
         count_q   <= count_d;
         addr_q    <= addr_d;
         stops_q   <= stops_d;
         full_q    <= full_d;
         ovf_q     <= ovf_d;
         stopOvf_q <= stopOvf_d;
         qResp     <= qResp_d;
         xResp     <= xResp_d;
      end
   end

   // ------------------------------------------------------------------
   // result memory
   // ------------------------------------------------------------------

   // write and read never meet: reads are refused while a run can write
   result_memory resultMem (                                           // R1
      .mclk    (mclk),
      .reset_n (reset_n),
      .wrEn    (memWrEn),
      .wrAddr  (addr_q),
      .wrWord  (count_q),
      .rdEn    (memRdEn),
      .rdAddr  (addr_q),
      .altWord (altWord),
      .rdWord  (rdData)
   );

endmodule : serial_time_interval_counter

// file: testbench/stic_checker.sv
// assertions on the command port of the interval counter
`timescale 1ns/100ps
`include "stic_consts.svh"

module stic_checker #(
   parameter logic [11:0] MODULE_NUMBER = `MODNUM_DEFAULT  // arbitrary identity value
) (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic [4:0]  cmdFunc,
   input wire logic [3:0]  cmdSub,
   input wire logic        wrStrobe,
   input wire logic        rdStrobe,
   input wire logic        initClear,
   input wire logic [23:0] rdData,
   input wire logic        qResp,
   input wire logic        xResp
);
   // ------------------------------------------------------------
   // answers one cycle after each strobe
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic ok0;
   // a clear outranks every command in its cycle, so it is kept out of the causes
   assign ok0 = cmdSub == `SUB_MAIN && !initClear;
   a_arm_answer: assert property (
      wrStrobe && cmdFunc == `FN_ARM && ok0 |=> xResp && qResp) else $error("arm unanswered");
   a_bad_sub: assert property (
      (wrStrobe || rdStrobe) && cmdSub != `SUB_MAIN && !initClear |=> !xResp && !qResp
      && rdData == 24'h000000) else $error("foreign subaddress answered");
   a_quiet_idle: assert property (
      !wrStrobe && !rdStrobe && !initClear |=> !xResp && !qResp && rdData == 24'h000000)
      else $error("answer without command");
   a_modnum_read: assert property (
      rdStrobe && cmdFunc == `FN_RD_MODNUM && ok0 |=> qResp && rdData == {12'h000, MODULE_NUMBER})
      else $error("module number wrong");
   a_clear_answer: assert property (
      initClear |=> xResp && !qResp) else $error("clear answer wrong");
   a_armed_refuse: assert property (
      wrStrobe && cmdFunc == `FN_ARM && ok0 ##2 rdStrobe && cmdFunc == `FN_RD_ADDR && ok0
      |=> !qResp && xResp && rdData == 24'h000000) else $error("armed read done");
   a_arm_status: assert property (
      wrStrobe && cmdFunc == `FN_ARM && ok0 ##2 rdStrobe && cmdFunc == `FN_RD_STATUS && ok0
      |=> rdData[19] && rdData[9:0] == 10'h000 && rdData[23:21] == 3'h0)
      else $error("arm status wrong");
   a_clear_status: assert property (
      initClear ##2 rdStrobe && cmdFunc == `FN_RD_STATUS && ok0
      |=> rdData[9:0] == 10'h000 && rdData[23:19] == 5'h00) else $error("clear left status");
   c_arm: cover property (wrStrobe && cmdFunc == `FN_ARM && ok0);
   c_count_read: cover property (rdStrobe && cmdFunc == `FN_RD_COUNT && ok0 ##1 qResp);
   c_clear: cover property (initClear);
endmodule : stic_checker

// file: testbench/panel_source.sv
// front-panel pulse source and 1 MHz bus clock feeding the counter's pins
`timescale 1ns/100ps

module panel_source (
   output logic dwClk,
   output logic extClk,
   output logic startP,
   output logic stopP,
   output logic disarmP
);
   initial begin
      {dwClk, extClk, startP, stopP, disarmP} = 5'h00;
   end
   // both clocks run free; their edges fall between mclk rising edges
   always #500 dwClk = ~dwClk;
   always #250 extClk = ~extClk;
   // a pulse is 60 ns high then 60 ns low, long enough for the synchroniser
   task automatic fire(input int pin);
      case (pin)
         0: startP = 1'b1;
         1: stopP = 1'b1;
         default: disarmP = 1'b1;
      endcase
      #60;
      {startP, stopP, disarmP} = 3'h0;
      #60;
   endtask : fire
endmodule : panel_source

// file: testbench/tb_top.sv
// self-checking bench of the serial time interval counter
`timescale 1ns/100ps
`include "stic_consts.svh"
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errorCnt++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
   import stic_pkg::*;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [4:0]  cmdFunc = 5'h00;
   logic [3:0]  cmdSub = 4'h0;
   logic [23:0] wrData = 24'h000000, rdData, rd;
   logic        wrStrobe = 1'b0, rdStrobe = 1'b0, initClear = 1'b0, clkSrcExtSw = 1'b0;
   logic        dwClk, extClk, startP, stopP, disarmP, qResp, xResp, q;
   divSel_t     divSelSw = DIV_BY_1;
   int          errorCnt = 0, checkCount = 0;
   always #5 mclk = ~mclk;
   panel_source src_u (.dwClk(dwClk), .extClk(extClk), .startP(startP), .stopP(stopP),
      .disarmP(disarmP));
   serial_time_interval_counter dut_u (.mclk(mclk), .reset_n(reset_n), .cmdFunc(cmdFunc),
      .cmdSub(cmdSub), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .initClear(initClear), .dwClkIn(dwClk), .extClkIn(extClk), .startIn(startP),
      .stopIn(stopP), .extDisarmIn(disarmP), .clkSrcExtSw(clkSrcExtSw), .divSelSw(divSelSw),
      .rdData(rdData), .qResp(qResp), .xResp(xResp));
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   // strobe for one edge, take the answer just after it, then leave one idle edge
   task automatic bus(input logic wr, input logic [4:0] f, input logic [23:0] d);
      cmdFunc  <= f;
      wrData   <= d;
      wrStrobe <= wr;
      rdStrobe <= !wr;
      @(posedge mclk);
      #1;
      {q, rd} = {qResp, rdData};
      {wrStrobe, rdStrobe} <= 2'b00;
      @(posedge mclk);
      #1;
   endtask : bus
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wt
   task automatic stat(input logic [23:0] e);
      bus(1'b0, `FN_RD_STATUS, 24'h000000);
      `CHK(rd, e)
   endtask : stat
   // the count clock phase against a pulse is free, so one tick either way is allowed
   task automatic rdcnt(input int n);
      bus(1'b0, `FN_RD_COUNT, 24'h000000);
      `CHK(rd inside {[n - 1:n + 1]}, 1'b1)
   endtask : rdcnt
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_boot;
      stat(24'h000000);
      clkSrcExtSw <= 1'b1;
      divSelSw    <= DIV_BY_1000;
      wt(6);
      stat(24'h070000);
      cmdSub <= 4'h1;
      stat(24'h000000);
      cmdSub <= 4'h0;
      {clkSrcExtSw, divSelSw} <= {1'b0, DIV_BY_1};
      wt(6);
      bus(1'b1, `FN_WR_ADDR, 24'h0003fe);
      repeat (2) bus(1'b0, `FN_RD_COUNT, 24'h000000);
      `CHK(q, 1'b1)
      bus(1'b0, `FN_RD_ADDR, 24'h000000);
      `CHK({q, rd}, 25'h1000000)
   endtask : t_boot
   task automatic t_run;
      bus(1'b1, `FN_ARM, 24'h000000);
      bus(1'b0, `FN_RD_ADDR, 24'h000000);
      `CHK(q, 1'b0)
      src_u.fire(0);
      #2880 src_u.fire(1);
      stat(24'h180001);
      #1400 src_u.fire(0);
      #1400 src_u.fire(1);
      #2880 src_u.fire(1);
      bus(1'b1, `FN_DISARM, 24'h000000);
      stat(24'h000003);
      bus(1'b0, `FN_RD_ADDR, 24'h000000);
      `CHK({q, rd}, 25'h1000000)
      rdcnt(3);
      rdcnt(6);
      rdcnt(9);
   endtask : t_run
   task automatic t_rearm;
      bus(1'b1, `FN_ARM, 24'h000000);
      src_u.fire(0);
      #2000 bus(1'b1, `FN_ARM, 24'h000000);
      stat(24'h080000);
      #2000 src_u.fire(0);
      #2880 src_u.fire(1);
      src_u.fire(2);
      wt(6);
      stat(24'h000001);
      rdcnt(3);
   endtask : t_rearm
   task automatic t_full;
      bus(1'b1, `FN_ARM, 24'h000000);
      src_u.fire(0);
      repeat (1024) src_u.fire(1);
      wt(6);
      stat(24'h200000);
      src_u.fire(1);
      bus(1'b0, `FN_RD_ADDR, 24'h000000);
      `CHK(rd, 24'h000000)
      bus(1'b1, `FN_WR_ADDR, 24'h0003ff);
      rdcnt(123);
      initClear <= 1'b1;
      wt(1);
      initClear <= 1'b0;
      wt(1);
      stat(24'h000000);
   endtask : t_full
   task automatic conclude;
      if (errorCnt == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      wt(2);
      t_boot;
      t_run;
      t_rearm;
      t_full;
      conclude;
   end
   // the whole run needs about 140 us
   initial begin
      #400000;
      errorCnt++;
      conclude;
   end
endmodule : tb_top

bind serial_time_interval_counter stic_checker #(.MODULE_NUMBER(MODULE_NUMBER)) chk_u (
   .mclk(mclk), .reset_n(reset_n), .cmdFunc(cmdFunc), .cmdSub(cmdSub), .wrStrobe(wrStrobe),
   .rdStrobe(rdStrobe), .initClear(initClear), .rdData(rdData), .qResp(qResp), .xResp(xResp));
